// >>> hdl/clock_select_defs.vh
// Offsets, field positions, reset values and timing counts of the clock selection block.
`ifndef CLOCK_SELECT_DEFS_VH
`define CLOCK_SELECT_DEFS_VH

// ==========================================================================
// Register offsets (byte addresses).
// ==========================================================================
`define OFS_CTRL        4'h0
`define OFS_MODEM_CLK   4'h4
`define OFS_TRIM        4'h8
`define OFS_STATUS      4'hC

// ==========================================================================
// Field positions and encodings.
// ==========================================================================
`define SRC_CRYSTAL     2'h0
`define SRC_EXT_CLOCK   2'h1
`define SRC_DCO         2'h2
`define SRC_INTERNAL    2'h3
`define CTRL_SRC_LSB    0
`define CTRL_BDC_SEL    2
`define CTRL_RTI_SEL    3
`define CTRL_MODEM_ON   4
`define CTRL_DEFAULT    5'h13
`define MCLK_DEFAULT    3'h6
`define TRIM_DEFAULT    8'h80
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ==========================================================================
// Timing figures.
// ==========================================================================
`define CPU_MAX_MHZ     40
`define BUS_MAX_MHZ     20
`define SYS_CLK_MHZ     200
`define MODEM_REF_MHZ   16
`define FFE_RATIO       4
`define CMP_WINDOW      16'h0400
`endif

// >>> hdl/system_clock_selection.v
// Clock selection and distribution for the microcontroller and modem clock output.
`timescale 1ns/1ps
`include "clock_select_defs.vh"

// How it works
// - Bus clock enable ticks at half the processor rate; limits 40 and 20 MHz.
// - Main output chooses crystal, external clock input, DIGITALLY_CONTROLLED_OSC or internal reference by control bits.
// - Fixed-freq select is 1 when main output exceeds four times external reference.
// - A self-clocked source near 8 MHz may clock the debug controller.
// - External reference may be chosen as real-time interrupt clock.
// - Modem clock out selects among eight rates, defaulting near 32.786 kHz.
// - Every modem output rate is divided from the 16 MHz reference.
// - Trimmable internal 243 kHz reference clocks startup and modem shutdown.
module system_clock_selection #(
  parameter CPU_DIV   = 5,   // 200 MHz / 5 = 40 MHz processor rate.
  parameter MODEM_DIV = 12,  // Crude 16 MHz reference stand-in: 200 / 16 = 12.5 rounds to 12.
  parameter LOCAL_DIV = 25,  // Self-clocked source, about 8 MHz.
  parameter INT_DIV   = 823, // Internal reference, about 243 kHz at mid trim.
  parameter DCO_DIV   = 10
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        crystal_tick,
  input  wire        ext_clock_tick,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         cpu_clk_en_ff,
  output reg         bus_clock_en_ff,
  output reg         clock_gen_main_output_ff,
  output reg         fixed_freq_clk_en_ff,
  output reg         fixed_freq_select_ff,
  output reg         bdc_clk_en_ff,
  output reg         rti_clk_en_ff,
  output reg         modem_clock_out_ff
);

  // ==========================================================================
  // Registers reached over the bus.
  // ==========================================================================
  reg [4:0]  ctrl_ff;
  reg [2:0]  mclk_sel_ff;
  reg [7:0]  trim_ff;
  reg [1:0]  src_act_ff;
  reg [2:0]  mclk_act_ff;
  reg        aw_hold_ff;
  reg        w_hold_ff;
  reg [3:0]  aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;

  // Address and data are latched in either order; the response follows both.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_hold_ff    <= 1'b0;
      w_hold_ff     <= 1'b0;
      aw_addr_ff    <= 4'h0;
      w_data_ff     <= 32'h0;
      w_strb_ff     <= 4'h0;
      // Start-up runs from the internal reference with the modem powered.
      ctrl_ff       <= `CTRL_DEFAULT;
      mclk_sel_ff   <= `MCLK_DEFAULT;
      trim_ff       <= `TRIM_DEFAULT;
    end else begin
      s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_ff && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (aw_hold_ff && w_hold_ff && !s_axi_bvalid) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (aw_addr_ff == `OFS_CTRL) begin
          if (w_strb_ff[0]) ctrl_ff <= w_data_ff[4:0];
        end else if (aw_addr_ff == `OFS_MODEM_CLK) begin
          if (w_strb_ff[0]) mclk_sel_ff <= w_data_ff[2:0];
        end else if (aw_addr_ff == `OFS_TRIM) begin
          if (w_strb_ff[0]) trim_ff <= w_data_ff[7:0];
        end else if (aw_addr_ff == `OFS_STATUS) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        if (s_axi_araddr == `OFS_CTRL) begin
          s_axi_rdata <= {27'h0, ctrl_ff};
        end else if (s_axi_araddr == `OFS_MODEM_CLK) begin
          s_axi_rdata <= {29'h0, mclk_sel_ff};
        end else if (s_axi_araddr == `OFS_TRIM) begin
          s_axi_rdata <= {24'h0, trim_ff};
        end else if (s_axi_araddr == `OFS_STATUS) begin
          s_axi_rdata <= {26'h0, fixed_freq_select_ff, mclk_act_ff, src_act_ff};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Internal sources: DIGITALLY_CONTROLLED_OSC, self-clocked source, trimmed internal reference.
  // ==========================================================================
  reg  [9:0] dco_cnt_ff;
  reg  [9:0] loc_cnt_ff;
  reg  [9:0] int_cnt_ff;
  wire [9:0] int_limit = INT_DIV[9:0] + {2'h0, trim_ff} - {2'h0, `TRIM_DEFAULT};
  wire       dco_tick  = (dco_cnt_ff == 10'h000);
  wire       loc_tick  = (loc_cnt_ff == 10'h000);
  wire       int_tick  = (int_cnt_ff == 10'h000);

  // Free-running dividers; trim moves the internal reference period.
  always @(posedge aclk) begin
    if (!aresetn) begin
      dco_cnt_ff <= 10'h000;
      loc_cnt_ff <= 10'h000;
      int_cnt_ff <= 10'h000;
    end else begin
      dco_cnt_ff <= dco_tick ? DCO_DIV[9:0] - 10'h001 : dco_cnt_ff - 10'h001;
      loc_cnt_ff <= loc_tick ? LOCAL_DIV[9:0] - 10'h001 : loc_cnt_ff - 10'h001;
      int_cnt_ff <= int_tick ? int_limit - 10'h001 : int_cnt_ff - 10'h001;
    end
  end

  // ==========================================================================
  // Main source selection.
  // ==========================================================================
  reg main_tick;

  // Four-way selector; the internal reference covers start-up and modem shutdown.
  always @* begin
    case (src_act_ff)
      `SRC_CRYSTAL:   main_tick = crystal_tick;
      `SRC_EXT_CLOCK: main_tick = ext_clock_tick;
      `SRC_DCO:       main_tick = dco_tick;
      default:        main_tick = int_tick;
    endcase
  end

  // A new source is adopted on a tick of the old one, so no short period appears; with the modem off the internal reference is taken at once.
  always @(posedge aclk) begin
    if (!aresetn) begin
      src_act_ff <= `SRC_INTERNAL;
    end else if (main_tick || !ctrl_ff[`CTRL_MODEM_ON]) begin
      src_act_ff <= ctrl_ff[`CTRL_MODEM_ON] ? ctrl_ff[1:0] : `SRC_INTERNAL;
    end
  end

  // ==========================================================================
  // Processor and bus rates.
  // ==========================================================================
  reg [3:0] cpu_cnt_ff;
  reg       half_ff;
  wire      cpu_tick = main_tick && (cpu_cnt_ff == 4'h0);

  // The processor rate is capped at 40 MHz; the bus gets every second processor tick.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_cnt_ff      <= 4'h0;
      half_ff         <= 1'b0;
      cpu_clk_en_ff   <= 1'b0;
      bus_clock_en_ff <= 1'b0;
      clock_gen_main_output_ff <= 1'b0;
    end else begin
      if (cpu_cnt_ff != 4'h0) cpu_cnt_ff <= cpu_cnt_ff - 4'h1;
      else if (main_tick) cpu_cnt_ff <= CPU_DIV[3:0] - 4'h1;
      cpu_clk_en_ff   <= cpu_tick;
      if (cpu_tick) half_ff <= !half_ff;
      bus_clock_en_ff <= cpu_tick && half_ff;
      clock_gen_main_output_ff <= main_tick;
    end
  end

  // ==========================================================================
  // Fixed-frequency select: count main ticks over a window of reference ticks.
  // ==========================================================================
  reg [15:0] ref_cnt_ff;
  reg [17:0] main_cnt_ff;

  // Window of CMP_WINDOW reference ticks; compare against four times that count.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_ff           <= 16'h0;
      main_cnt_ff          <= 18'h0;
      fixed_freq_select_ff <= 1'b0;
      fixed_freq_clk_en_ff <= 1'b0;
      bdc_clk_en_ff        <= 1'b0;
      rti_clk_en_ff        <= 1'b0;
    end else begin
      if (crystal_tick && ref_cnt_ff == `CMP_WINDOW - 16'h1) begin
        ref_cnt_ff  <= 16'h0;
        main_cnt_ff <= 18'h0;
        fixed_freq_select_ff <= main_cnt_ff > ({2'h0, `CMP_WINDOW} << 2);
      end else begin
        if (crystal_tick) ref_cnt_ff <= ref_cnt_ff + 16'h1;
        if (main_tick && main_cnt_ff != 18'h3FFFF) main_cnt_ff <= main_cnt_ff + 18'h1;
      end
      fixed_freq_clk_en_ff <= fixed_freq_select_ff ? crystal_tick : (cpu_tick && half_ff);
      bdc_clk_en_ff <= ctrl_ff[`CTRL_BDC_SEL] ? loc_tick : (cpu_tick && half_ff);
      rti_clk_en_ff <= ctrl_ff[`CTRL_RTI_SEL] ? crystal_tick : int_tick;
    end
  end

  // ==========================================================================
  // Modem clock output divided from the 16 MHz reference.
  // ==========================================================================
  reg  [3:0]  ref_div_ff;
  reg  [8:0]  mdiv_ff;
  wire        ref16_tick = (ref_div_ff == 4'h0);
  reg  [8:0]  half_period;

  // Half periods in reference ticks: 16 MHz, 8, 4, 2, 1, 62.5 kHz, ~32.8, ~16.4 kHz.
  always @* begin
    case (mclk_act_ff)
      3'h0:    half_period = 9'h001;
      3'h1:    half_period = 9'h001;
      3'h2:    half_period = 9'h002;
      3'h3:    half_period = 9'h004;
      3'h4:    half_period = 9'h008;
      3'h5:    half_period = 9'h080;
      3'h6:    half_period = 9'h0F4;
      default: half_period = 9'h1E8;
    endcase
  end

  // The setting is switched as the output falls at the end of a period; in setting 0 it is switched on each reference tick.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_div_ff         <= 4'h0;
      mdiv_ff            <= 9'h000;
      mclk_act_ff        <= `MCLK_DEFAULT;
      modem_clock_out_ff <= 1'b0;
    end else begin
      ref_div_ff <= ref16_tick ? MODEM_DIV[3:0] - 4'h1 : ref_div_ff - 4'h1;
      if (mclk_act_ff == 3'h0) begin
        modem_clock_out_ff <= ref16_tick; // 16 MHz passes as a one-tick pulse.
        if (ref16_tick) mclk_act_ff <= mclk_sel_ff;
      end else if (ref16_tick) begin
        if (mdiv_ff + 9'h001 >= half_period) begin
          mdiv_ff <= 9'h000;
          modem_clock_out_ff <= !modem_clock_out_ff;
          if (modem_clock_out_ff) mclk_act_ff <= mclk_sel_ff;
        end else begin
          mdiv_ff <= mdiv_ff + 9'h001;
        end
      end
    end
  end

endmodule

// >>> tb/tick_source.sv
// Partner model: free-running tick source for the crystal and the external clock input.
`timescale 1ns/1ps
module tick_source (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [7:0] period,
  output reg        tick_ff
);
  reg [7:0] cnt_ff;
  // An oscillator never waits for the bus, so the count runs on regardless of traffic.
  always @(posedge aclk) begin
    cnt_ff  <= (!aresetn || cnt_ff + 8'h01 >= period) ? 8'h00 : cnt_ff + 8'h01;
    tick_ff <= aresetn && (cnt_ff + 8'h01 >= period);
  end
endmodule

// >>> tb/system_clock_selection_properties.sv
// Concurrent checks on the ports of the clock selection block.
`timescale 1ns/1ps
module clock_sel_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        crystal_tick,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        cpu_clk_en_ff,
  input wire        bus_clock_en_ff,
  input wire        clock_gen_main_output_ff,
  input wire        fixed_freq_clk_en_ff,
  input wire        fixed_freq_select_ff,
  input wire        modem_clock_out_ff
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // =====
  // Enables: minimum spacing fixed by the default divider, so a divider that counts short shows at once.
  // The source period sets the rate, so only the 40 MHz and 20 MHz ceilings are fixed here.
  cpu_rate_a: assert property (cpu_clk_en_ff |=> !cpu_clk_en_ff [*4])
    else $error("processor enable above its rate ceiling");
  bus_rate_a: assert property (bus_clock_en_ff |=> !bus_clock_en_ff [*8] ##1 !bus_clock_en_ff)
    else $error("bus enable above its rate ceiling");
  bus_on_cpu_a: assert property (bus_clock_en_ff |-> cpu_clk_en_ff || $past(cpu_clk_en_ff))
    else $error("bus enable not aligned to processor enable");
  main_pulse_a: assert property (clock_gen_main_output_ff |=> !clock_gen_main_output_ff)
    else $error("main output pulse too long");
  ffe_bus_a: assert property (!fixed_freq_select_ff && !$past(fixed_freq_select_ff) && fixed_freq_clk_en_ff
    |-> bus_clock_en_ff || $past(bus_clock_en_ff))
    else $error("fixed clock not from bus clock");
  ffe_ref_a: assert property (fixed_freq_select_ff && $past(fixed_freq_select_ff) && fixed_freq_clk_en_ff
    |-> $past(crystal_tick) || $past(crystal_tick, 2))
    else $error("fixed clock not from reference");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !(cpu_clk_en_ff | bus_clock_en_ff |
    clock_gen_main_output_ff | fixed_freq_select_ff | modem_clock_out_ff))
    else $error("outputs active after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  cover property (fixed_freq_select_ff);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(modem_clock_out_ff));
endmodule
bind system_clock_selection clock_sel_checker i_clock_sel_checker (.aclk(aclk), .aresetn(aresetn),
  .crystal_tick(crystal_tick), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpu_clk_en_ff(cpu_clk_en_ff),
  .bus_clock_en_ff(bus_clock_en_ff), .clock_gen_main_output_ff(clock_gen_main_output_ff),
  .fixed_freq_clk_en_ff(fixed_freq_clk_en_ff), .fixed_freq_select_ff(fixed_freq_select_ff),
  .modem_clock_out_ff(modem_clock_out_ff));

// >>> tb/test_system_clock_selection.sv
// Self-checking bench for the clock selection block.
`timescale 1ns/1ps
module test_system_clock_selection;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [3:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [7:0]  xper, eper;
  wire        xtick, etick, awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [7:0]  sig;
  integer     err_count, comparisons, cycles, s;
  // Modem period in reference ticks per setting, from 16 MHz down to about 16.393 kHz.
  function integer mod_per(input integer k);
    if (k < 5) mod_per = 1 << k;
    else if (k == 5) mod_per = 256;
    else mod_per = 488 << (k - 6);
  endfunction
  // Main source period in cycles: crystal, external clock input, oscillator.
  function integer src_per(input integer k);
    if (k == 0) src_per = 9;
    else if (k == 1) src_per = 7;
    else src_per = 10;
  endfunction
  // Modem reference shortened to one tick per 4 cycles; sig packs the enables for measuring.
  system_clock_selection #(.MODEM_DIV(4)) i_system_clock_selection (.aclk(aclk), .aresetn(aresetn),
    .crystal_tick(xtick), .ext_clock_tick(etick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_clk_en_ff(sig[6]),
    .bus_clock_en_ff(sig[0]), .clock_gen_main_output_ff(sig[1]), .fixed_freq_clk_en_ff(sig[2]),
    .fixed_freq_select_ff(sig[7]), .bdc_clk_en_ff(sig[3]), .rti_clk_en_ff(sig[4]),
    .modem_clock_out_ff(sig[5]));
  tick_source i_tick_source_x (.aclk(aclk), .aresetn(aresetn), .period(xper), .tick_ff(xtick));
  tick_source i_tick_source_e (.aclk(aclk), .aresetn(aresetn), .period(eper), .tick_ff(etick));
  // =====
  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 100000) begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  // =====
  // Shared tasks: compare, bus cycles and period measurement.
  task automatic chk(input [31:0] got, input [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input [3:0] a, input [31:0] d, input [1:0] er);
    integer n;
    reg     done;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 50 && !done; n = n + 1) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk(bresp, er);
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) chk(32'h0, 32'h1);
  endtask
  task automatic rd(input [3:0] a, input [31:0] exp, input [1:0] er);
    integer n;
    reg     done;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 50 && !done; n = n + 1) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(rdata, exp);
        chk(rresp, er);
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) chk(32'h0, 32'h1);
  endtask
  // The first interval may straddle a setting change, so the second whole one is judged.
  task automatic per(input integer w, input integer exp);
    integer n, t0, k, p;
    reg     last;
    last = 1'b1;
    k = 0;
    t0 = 0;
    p = 0;
    for (n = 0; n < 30000 && k < 3; n = n + 1) begin
      @(posedge aclk);
      #1;
      if (sig[w] && !last) begin
        k = k + 1;
        p = n - t0;
        t0 = n;
      end
      last = sig[w];
    end
    chk(p, exp);
  endtask
  // =====
  // Scenarios.
  task automatic t_reset;
    rd(4'h0, 32'h13, 2'h0);
    rd(4'h4, 32'h6, 2'h0);
    rd(4'h8, 32'h80, 2'h0);
    rd(4'hC, 32'h1B, 2'h0);
    rd(4'h2, 32'h0, 2'h2);
    wr(4'h2, 32'h0, 2'h2);
    $display("reset test done");
  endtask
  task automatic t_modem;
    for (s = 0; s < 8; s = s + 1) begin
      wr(4'h4, s, 2'h0);
      per(5, mod_per(s) * 4);
      rd(4'hC, {s[2:0], 2'h3}, 2'h0);
    end
    wr(4'h4, 32'h6, 2'h0);
    per(5, mod_per(6) * 4);
    $display("modem test done");
  endtask
  task automatic t_source;
    for (s = 0; s < 3; s = s + 1) begin
      wr(4'h0, 32'h10 | s, 2'h0);
      per(1, src_per(s));
      per(6, src_per(s));
      rd(4'hC, 32'h18 | s, 2'h0);
    end
    per(2, 2 * src_per(2));
    per(0, 2 * src_per(2));
    $display("source test done");
  endtask
  task automatic t_debug;
    wr(4'h0, 32'h1C, 2'h0);
    per(3, 25);
    per(4, 9);
    wr(4'h0, 32'h10, 2'h0);
    per(3, 2 * src_per(0));
    per(4, 823);
    $display("debug test done");
  endtask
  task automatic t_low_power;
    wr(4'h0, 32'h00, 2'h0);
    rd(4'hC, 32'h1B, 2'h0);
    wr(4'h8, 32'h5A, 2'h0);
    rd(4'h8, 32'h5A, 2'h0);
    wr(4'hC, 32'hFF, 2'h0);
    rd(4'hC, 32'h1B, 2'h0);
    $display("low power test done");
  endtask
  task automatic t_fixed;
    integer n;
    eper <= 8'h02;
    wr(4'h0, 32'h11, 2'h0);
    for (n = 0; n < 30000 && sig[7] !== 1'b1; n = n + 1) @(posedge aclk);
    chk(sig[7], 1'b1);
    per(2, 9);
    rd(4'hC, 32'h39, 2'h0);
    $display("fixed clock test done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 40'h0;
    xper = 8'h09;
    eper = 8'h07;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_modem;
    t_source;
    t_debug;
    t_low_power;
    t_fixed;
    finish_test;
  end
endmodule
